// [hdl/eag_pkg.sv]
// Constants, field positions and carrier types for the effective address generator.
// Assumes one 20 MHz clock, an APB register port and a core memory with a req/ack handshake.
package eag_pkg;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int WORD_W = 18;
  localparam int ADDR_W = 17;
  localparam int PADDR_W = 8;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [PADDR_W-1:0] OFF_INSTR = 8'h00;
  localparam logic [PADDR_W-1:0] OFF_PC = 8'h04;
  localparam logic [PADDR_W-1:0] OFF_INDEX = 8'h08;
  localparam logic [PADDR_W-1:0] OFF_CTRL = 8'h0c;
  localparam logic [PADDR_W-1:0] OFF_STATUS = 8'h10;
  localparam logic [PADDR_W-1:0] OFF_EA = 8'h14;
  localparam logic [PADDR_W-1:0] OFF_XCYC = 8'h18;

  localparam int CTRL_START = 0;
  localparam int CTRL_PAGE = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam logic PAGE_RST = 1'b1;

  // ------------------------------------------------------------
  // Word bit positions: word bit 0 is the most significant, so word bit n sits at index 17-n.
  // ------------------------------------------------------------
  localparam int IND_POS = 13;
  localparam int IDX_POS = 12;
  localparam int PAGE_FLD_W = 12;
  localparam int BANK_FLD_W = 13;
  localparam int PC_PAGE_LO = 12;
  localparam int PC_BANK_LO = 13;
  localparam int PC_BLK_LO = 15;
  localparam int PTR_W = 15;
  localparam logic [BANK_FLD_W-1:0] AUTO_FIRST = 13'h0008;
  localparam logic [BANK_FLD_W-1:0] AUTO_LAST = 13'h000f;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_RD1 = 4'h2,
    ST_WR = 4'h4,
    ST_RD2 = 4'h8
  } eag_state_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } eag_mem_req_t;

  typedef struct packed {
    eag_state_t st;
    logic go;
    logic [WORD_W-1:0] instr;
    logic [ADDR_W-1:0] pc;
    logic [WORD_W-1:0] index;
    logic page;
    logic done;
    logic auto_inc;
    logic post_idx;
    logic [ADDR_W-1:0] ea;
    logic [WORD_W-1:0] ptr;
    logic [1:0] xcyc;
    eag_mem_req_t mem;
    logic [31:0] prdata;
  } eag_regs_t;

  localparam eag_mem_req_t MEM_IDLE = '{req: 1'b0, we: 1'b0, addr: '0, wdata: '0};
  localparam eag_regs_t REGS_RST = '{st: ST_IDLE, go: 1'b0, instr: '0, pc: '0, index: '0,
                                     page: PAGE_RST, done: 1'b0, auto_inc: 1'b0,
                                     post_idx: 1'b0, ea: '0, ptr: '0, xcyc: '0,
                                     mem: MEM_IDLE, prdata: '0};

endpackage

// [hdl/eag_top.sv]
// Effective address generator for memory reference instructions of an 18-bit word machine.
// Assumes an APB master for software and a core memory that holds each request until ack.
`timescale 1ns/10ps

module eag_top
  import eag_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic NRST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [PADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic MEM_REQ_O,
  output logic MEM_WE_O,
  output logic [ADDR_W-1:0] MEM_ADDR_O,
  output logic [WORD_W-1:0] MEM_WDATA_O,
  input wire logic [WORD_W-1:0] MEM_RDATA_I,
  input wire logic MEM_ACK_I,
  output logic BUSY_O,
  output logic [ADDR_W-1:0] EA_O
);

  // ------------------------------------------------------------
  // Instruction decode
  // ------------------------------------------------------------
  eag_regs_t r_reg;
  eag_regs_t r_next;
  logic is_ind;
  logic is_idx;
  logic is_auto;
  logic busy;
  logic [BANK_FLD_W-1:0] fld;
  logic [ADDR_W-1:0] dir_addr;
  logic [ADDR_W-1:0] seg_addr;
  logic [ADDR_W-1:0] auto_addr;
  logic [WORD_W-1:0] idx_sum;
  logic [WORD_W-1:0] post_sum;
  logic [WORD_W-1:0] inc_word;
  logic wr_acc;
  logic mapped;

  assign is_ind = r_reg.instr[IND_POS];
  assign is_idx = r_reg.page & r_reg.instr[IDX_POS];
  assign fld = r_reg.page ? {1'b0, r_reg.instr[PAGE_FLD_W-1:0]}
                          : r_reg.instr[BANK_FLD_W-1:0];
  assign is_auto = is_ind && (fld >= AUTO_FIRST) && (fld <= AUTO_LAST);
  assign seg_addr = {r_reg.pc[ADDR_W-1:PC_PAGE_LO], r_reg.instr[PAGE_FLD_W-1:0]};
  // Bank mode keeps the program's own bank bits; only indirect references through 8-15 are redirected to block 0.
  assign dir_addr = r_reg.page ? seg_addr
                               : {r_reg.pc[ADDR_W-1:PC_BANK_LO],
                                  r_reg.instr[BANK_FLD_W-1:0]};
  assign auto_addr = {{(ADDR_W-BANK_FLD_W){1'b0}}, fld};
  assign idx_sum = r_reg.index + {1'b0, seg_addr};
  assign post_sum = r_reg.index + {1'b0, r_reg.pc[ADDR_W-1:PC_BLK_LO],
                                   MEM_RDATA_I[PTR_W-1:0]};
  assign inc_word = MEM_RDATA_I + 18'h00001;

  // ------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------
  // Zero wait states: read data is latched in the setup cycle and stands in the access cycle.
  assign busy = (r_reg.st != ST_IDLE) | r_reg.go;
  assign mapped = PADDR_I inside {OFF_INSTR, OFF_PC, OFF_INDEX, OFF_CTRL, OFF_STATUS,
                                  OFF_EA, OFF_XCYC};
  assign wr_acc = PSEL_I & PENABLE_I & PWRITE_I;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;
  assign PRDATA_O = r_reg.prdata;
  assign MEM_REQ_O = r_reg.mem.req;
  assign MEM_WE_O = r_reg.mem.we;
  assign MEM_ADDR_O = r_reg.mem.addr;
  assign MEM_WDATA_O = r_reg.mem.wdata;
  assign BUSY_O = busy;
  assign EA_O = r_reg.ea;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    r_next = r_reg;
    r_next.go = 1'b0;
    if (wr_acc)
    begin
      // Operands are frozen while a calculation runs so the result stays consistent.
      unique case (PADDR_I)
        OFF_INSTR: if (!busy) r_next.instr = PWDATA_I[WORD_W-1:0];
        OFF_PC: if (!busy) r_next.pc = PWDATA_I[ADDR_W-1:0];
        OFF_INDEX: if (!busy) r_next.index = PWDATA_I[WORD_W-1:0];
        OFF_CTRL:
        begin
          if (!busy)
          begin
            r_next.page = PWDATA_I[CTRL_PAGE];
            r_next.go = PWDATA_I[CTRL_START];
          end
        end
        default: r_next.go = 1'b0;
      endcase
    end
    if (PSEL_I && !PENABLE_I && !PWRITE_I)
    begin
      unique case (PADDR_I)
        OFF_INSTR: r_next.prdata = {14'h0000, r_reg.instr};
        OFF_PC: r_next.prdata = {15'h0000, r_reg.pc};
        OFF_INDEX: r_next.prdata = {14'h0000, r_reg.index};
        OFF_CTRL: r_next.prdata = {30'h00000000, r_reg.page, 1'b0};
        OFF_STATUS: r_next.prdata = {30'h00000000, r_reg.done, busy};
        OFF_EA: r_next.prdata = {15'h0000, r_reg.ea};
        OFF_XCYC: r_next.prdata = {30'h00000000, r_reg.xcyc};
        default: r_next.prdata = 32'h00000000;
      endcase
    end
    unique case (r_reg.st)
      ST_IDLE:
      begin
        if (r_reg.go)
        begin
          r_next.done = 1'b0;
          r_next.xcyc = 2'h0;
          r_next.auto_inc = is_auto;
          r_next.post_idx = is_idx;
          if (!is_ind)
          begin
            // Direct and plain indexed forms finish with no memory cycle.
            r_next.ea = is_idx ? idx_sum[ADDR_W-1:0] : dir_addr;
            r_next.done = 1'b1;
          end
          else
          begin
            r_next.st = ST_RD1;
            r_next.mem = '{req: 1'b1, we: 1'b0,
                           addr: is_auto ? auto_addr : dir_addr, wdata: '0};
          end
        end
      end
      ST_RD1:
      begin
        if (MEM_ACK_I)
        begin
          r_next.xcyc = r_reg.xcyc + 2'h1;
          if (r_reg.auto_inc)
          begin
            r_next.ptr = inc_word;
            r_next.st = ST_WR;
            r_next.mem = '{req: 1'b1, we: 1'b1, addr: r_reg.mem.addr, wdata: inc_word};
          end
          else
          begin
            r_next.ea = r_reg.post_idx ? post_sum[ADDR_W-1:0]
                                       : {2'b00, MEM_RDATA_I[PTR_W-1:0]};
            r_next.st = ST_IDLE;
            r_next.mem = MEM_IDLE;
            r_next.done = 1'b1;
          end
        end
      end
      ST_WR:
      begin
        if (MEM_ACK_I)
        begin
          r_next.xcyc = r_reg.xcyc + 2'h1;
          if (r_reg.post_idx)
          begin
            r_next.st = ST_RD2;
            r_next.mem = '{req: 1'b1, we: 1'b0, addr: r_reg.ptr[ADDR_W-1:0], wdata: '0};
          end
          else
          begin
            // The pointer holds 18 bits; only the low 17 form an address.
            r_next.ea = r_reg.ptr[ADDR_W-1:0];
            r_next.st = ST_IDLE;
            r_next.mem = MEM_IDLE;
            r_next.done = 1'b1;
          end
        end
      end
      ST_RD2:
      begin
        if (MEM_ACK_I)
        begin
          r_next.xcyc = r_reg.xcyc + 2'h1;
          r_next.ea = post_sum[ADDR_W-1:0];
          r_next.st = ST_IDLE;
          r_next.mem = MEM_IDLE;
          r_next.done = 1'b1;
        end
      end
      default:
      begin
        r_next.st = ST_IDLE;
        r_next.mem = MEM_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (!NRST_I)
      r_reg <= REGS_RST;
    else
      r_reg <= r_next;
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!NRST_I);

  sequence s_go;
    r_reg.go && (r_reg.st == ST_IDLE);
  endsequence

  sequence s_rd1_ack;
    (r_reg.st == ST_RD1) && MEM_ACK_I;
  endsequence

  sequence s_wr_ack;
    (r_reg.st == ST_WR) && MEM_ACK_I;
  endsequence

  sequence s_rd2_ack;
    (r_reg.st == ST_RD2) && MEM_ACK_I;
  endsequence

  property p_direct_plain;
    s_go and (!is_ind && !is_idx) |=> r_reg.done && !MEM_REQ_O && (EA_O == $past(dir_addr));
  endproperty
  a_direct_plain: assert property (p_direct_plain) else $error("direct address wrong");

  property p_index_direct;
    s_go and (!is_ind && is_idx) |=> r_reg.done && !MEM_REQ_O
                                    && (EA_O == $past(idx_sum[ADDR_W-1:0]));
  endproperty
  a_index_direct: assert property (p_index_direct) else $error("indexed address wrong");

  property p_bank_no_index;
    s_go and (!r_reg.page && !is_ind) |=> !r_reg.post_idx
        && (EA_O == {$past(r_reg.pc[ADDR_W-1:PC_BANK_LO]),
                     $past(r_reg.instr[BANK_FLD_W-1:0])});
  endproperty
  a_bank_no_index: assert property (p_bank_no_index) else $error("index in bank mode");

  property p_auto_target;
    s_go and is_auto |=> MEM_REQ_O && !MEM_WE_O && (MEM_ADDR_O[ADDR_W-1:4] == '0)
                         && (MEM_ADDR_O[3] == 1'b1);
  endproperty
  a_auto_target: assert property (p_auto_target) else $error("auto register not in block 0");

  property p_ptr_fetch;
    s_go and (is_ind && is_idx && !is_auto) |=> MEM_REQ_O && (MEM_ADDR_O == $past(seg_addr));
  endproperty
  a_ptr_fetch: assert property (p_ptr_fetch) else $error("pointer address wrong");

  property p_inc_back;
    s_rd1_ack and r_reg.auto_inc |=> MEM_WE_O && (MEM_WDATA_O == $past(MEM_RDATA_I) + 18'h00001)
                                    && (MEM_ADDR_O == $past(MEM_ADDR_O));
  endproperty
  a_inc_back: assert property (p_inc_back) else $error("increment write back wrong");

  property p_plain_ind;
    s_rd1_ack and (!r_reg.auto_inc && !r_reg.post_idx) |=> r_reg.done && !MEM_REQ_O
        && (EA_O == {2'b00, $past(MEM_RDATA_I[PTR_W-1:0])});
  endproperty
  a_plain_ind: assert property (p_plain_ind) else $error("indirect address wrong");

  property p_auto_idx_fetch;
    (r_reg.st == ST_WR) && MEM_ACK_I && r_reg.post_idx |=> !MEM_WE_O
        && (MEM_ADDR_O == $past(MEM_WDATA_O[ADDR_W-1:0]));
  endproperty
  a_auto_idx_fetch: assert property (p_auto_idx_fetch) else $error("second fetch wrong");

  property p_post_index;
    ((r_reg.st == ST_RD2) || ((r_reg.st == ST_RD1) && !r_reg.auto_inc && r_reg.post_idx))
        && MEM_ACK_I |=> (EA_O == $past(r_reg.index[ADDR_W-1:0]) + {$past(r_reg.pc[16:15]),
                                           $past(MEM_RDATA_I[PTR_W-1:0])});
  endproperty
  a_post_index: assert property (p_post_index) else $error("post index sum wrong");

  // ------------------------------------------------------------
  // Memory cycle sequencing
  // ------------------------------------------------------------
  // The page and bank checks rebuild their addresses from the raw operand fields rather than from the decode
  // nets, so a slip in the shared decode shows up here as well.
  property p_page_direct;
    s_go and (r_reg.page && !is_ind && !is_idx) |=> r_reg.done
        && (EA_O == {$past(r_reg.pc[ADDR_W-1:PC_PAGE_LO]),
                     $past(r_reg.instr[PAGE_FLD_W-1:0])});
  endproperty
  a_page_direct: assert property (p_page_direct) else $error("page address wrong");

  property p_ind_start;
    s_go and is_ind |=> MEM_REQ_O && !MEM_WE_O && BUSY_O && !r_reg.done;
  endproperty
  a_ind_start: assert property (p_ind_start) else $error("pointer fetch missing");

  property p_bank_ptr;
    s_go and (!r_reg.page && is_ind && !is_auto) |=> !r_reg.post_idx && MEM_REQ_O
        && (MEM_ADDR_O == {$past(r_reg.pc[ADDR_W-1:PC_BANK_LO]),
                           $past(r_reg.instr[BANK_FLD_W-1:0])});
  endproperty
  a_bank_ptr: assert property (p_bank_ptr) else $error("bank pointer address wrong");

  property p_auto_ea;
    s_wr_ack and !r_reg.post_idx |=> r_reg.done && !MEM_REQ_O
        && (EA_O == $past(MEM_WDATA_O[ADDR_W-1:0]));
  endproperty
  a_auto_ea: assert property (p_auto_ea) else $error("auto increment address wrong");

  property p_ind_idx_cycles;
    s_rd1_ack and (r_reg.post_idx && !r_reg.auto_inc) |=> r_reg.done && (r_reg.xcyc == 2'h1);
  endproperty
  a_ind_idx_cycles: assert property (p_ind_idx_cycles) else $error("cycles wrong");

  property p_auto_idx_cycles;
    s_rd2_ack |=> r_reg.done && !BUSY_O && (r_reg.xcyc == 2'h3);
  endproperty
  a_auto_idx_cycles: assert property (p_auto_idx_cycles) else $error("cycles wrong");

endmodule

// [sim/eag_mem_model.sv]
// Core memory model that serves the read and write cycles of the address generator.
// Assumes a request held until ack, and ack given as a one-cycle pulse.
`timescale 1ns/10ps
module eag_mem_model
  import eag_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [WORD_W-1:0] wdata_i,
  input wire logic [3:0] lat_i,
  output logic [WORD_W-1:0] rdata_o,
  output logic ack_o
);
  logic [WORD_W-1:0] mem [int];
  logic [3:0] cnt = 4'h0;

  initial
  begin
    rdata_o = 18'h15555;
    ack_o = 1'b0;
  end

  // ------------------------------------------------------------
  // Access timing
  // ------------------------------------------------------------
  // Read data is valid only with ack; otherwise the bus toggles, so a design that
  // samples it at the wrong edge cannot pick up the right word by luck.
  always @(posedge clk_i)
  begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (!nrst_i)
      cnt <= 4'h0;
    else if (req_i && !ack_o)
    begin
      if (cnt >= lat_i)
      begin
        ack_o <= 1'b1;
        cnt <= 4'h0;
        if (we_i)
          mem[int'(addr_i)] = wdata_i;
        else
          rdata_o <= mem.exists(int'(addr_i)) ? mem[int'(addr_i)] : 18'h00000;
      end
      else
        cnt <= cnt + 4'h1;
    end
  end
endmodule

// [sim/testbench.sv]
// Self-checking bench for the effective address generator, driven over APB.
// Assumes the core memory model eag_mem_model on the memory side.
`timescale 1ns/10ps
module testbench
  import eag_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, mreq, mwe, mack, busy, err;
  logic [ADDR_W-1:0] maddr, ea;
  logic [WORD_W-1:0] mwdata, mrdata, f;
  logic [3:0] lat = 4'h0;
  logic [31:0] q;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_cyc = 0;
  int n_clk = 0;

  eag_top eag_top_inst (.SYS_CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .MEM_REQ_O(mreq), .MEM_WE_O(mwe),
    .MEM_ADDR_O(maddr), .MEM_WDATA_O(mwdata), .MEM_RDATA_I(mrdata), .MEM_ACK_I(mack),
    .BUSY_O(busy), .EA_O(ea));
  eag_mem_model eag_mem_model_inst (.clk_i(clk), .nrst_i(nrst), .req_i(mreq), .we_i(mwe),
    .addr_i(maddr), .wdata_i(mwdata), .lat_i(lat), .rdata_o(mrdata), .ack_o(mack));

  initial
  begin
    forever #25 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    n_clk <= n_clk + 1;
    if (mreq && mack)
      n_cyc <= n_cyc + 1;
    if (n_clk == 10000)
    begin
      n_mismatch++;
      complete_run;
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h, expected %h", $time, g, e);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    // Only pready high or the bench timeout ends this wait.
    while (pready !== 1'b1)
      @(posedge clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  // One full calculation: load operands, start, wait for done, compare result and cycles.
  task automatic calc(input logic pg, input logic [17:0] ins, input logic [16:0] pc,
                      input logic [17:0] xr, input logic [16:0] exp, input int cyc);
    apb(1'b1, OFF_INSTR, {14'h0, ins});
    apb(1'b1, OFF_PC, {15'h0, pc});
    apb(1'b1, OFF_INDEX, {14'h0, xr});
    apb(1'b1, OFF_CTRL, {30'h0, pg, 1'b1});
    n_cyc = 0;
    // The first status read falls while a memory form is still on its first fetch.
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(q, (cyc > 0) ? 32'h1 : 32'h2);
    while (q[STAT_DONE] !== 1'b1)
      apb(1'b0, OFF_STATUS, 32'h0);
    chk({31'h0, busy}, 32'h0);
    chk({15'h0, ea}, {15'h0, exp});
    apb(1'b0, OFF_EA, 32'h0);
    chk(q, {15'h0, exp});
    apb(1'b0, OFF_XCYC, 32'h0);
    chk(q, cyc);
    chk(n_cyc, cyc);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    eag_mem_model_inst.mem[32'h249] = 18'h1f0c0;
    eag_mem_model_inst.mem[32'h10040] = 18'h00e00;
    eag_mem_model_inst.mem[32'h200] = 18'h01600;
    eag_mem_model_inst.mem[32'h100d] = 18'h00123;
    for (int i = 7; i < 17; i++)
    begin
      eag_mem_model_inst.mem[i] = 18'h00fff;
      eag_mem_model_inst.mem[32'h4000 + i] = 18'h00123;
    end
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(q, 32'h2);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    chk(q, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test registers done");
    calc(1'b1, 18'h10492, 17'h00040, 18'h0, 17'h00492, 0);
    calc(1'b0, 18'h10008, 17'h04000, 18'h0, 17'h04008, 0);
    calc(1'b0, 18'h11040, 17'h04000, 18'h0, 17'h05040, 0);
    $display("test direct done");
    lat <= 4'h3;
    calc(1'b1, 18'h12249, 17'h00080, 18'h0, 17'h070c0, 1);
    for (int i = 7; i < 17; i += 3)
    begin
      f = 18'(i);
      if (i >= 8 && i <= 15)
        calc(1'b0, 18'h12000 | f, 17'h04000, 18'h0, 17'h01000, 2);
      else
        calc(1'b0, 18'h12000 | f, 17'h04000, 18'h0, 17'h00123, 1);
      chk({14'h0, eag_mem_model_inst.mem[i]}, (i >= 8 && i <= 15) ? 32'h1000 : 32'hfff);
    end
    calc(1'b1, 18'h1200b, 17'h13000, 18'h0, 17'h01000, 2);
    chk({14'h0, eag_mem_model_inst.mem[11]}, 32'h1000);
    $display("test indirect done");
    lat <= 4'h0;
    calc(1'b1, 18'h11200, 17'h11600, 18'h2f000, 17'h00200, 0);
    calc(1'b1, 18'h11200, 17'h11600, 18'h0e000, 17'h1f200, 0);
    calc(1'b1, 18'h07040, 17'h10600, 18'h00040, 17'h10e40, 1);
    lat <= 4'h2;
    eag_mem_model_inst.mem[13] = 18'h001ff;
    calc(1'b1, 18'h0700d, 17'h0f0a5, 18'h3f200, 17'h08800, 3);
    chk({14'h0, eag_mem_model_inst.mem[13]}, 32'h200);
    calc(1'b0, 18'h1300d, 17'h00000, 18'h0, 17'h00123, 1);
    $display("test indexed done");
    complete_run;
  end
endmodule
